// File: include/fic_defs.svh
// Constants for the float and integer conversion datapath
`ifndef FIC_DEFS_SVH
`define FIC_DEFS_SVH

`define FIC_EXP_BIAS     8'h7F
`define FIC_EXP_ALL1     8'hFF
`define FIC_EXP_TOP      8'h9E
`define FIC_FRAC_W       9'h017
`define FIC_SHIFT_LIM    9'h020
`define FIC_I16_POS_MAX  32'h0000_7FFF
`define FIC_I16_NEG_MAG  32'h0000_8000
`define FIC_I32_POS_MAX  32'h7FFF_FFFF
`define FIC_I32_NEG_MAG  32'h8000_0000
`define FIC_RES_RST      32'h0000_0000

`endif

// File: include/fic_pkg.sv
// Types shared by the float and integer conversion datapath
`default_nettype none
package fic_pkg;

  // Conversion opcodes as issued by the sequencer
  typedef enum logic [9:0] {
    FIC_OP_F2I16 = 10'h1C2,
    FIC_OP_F2I32 = 10'h1C3,
    FIC_OP_I16F  = 10'h1C4,
    FIC_OP_I32F  = 10'h1C5
  } fic_op_e;

  // Result condition flags
  typedef struct packed {
    logic error_flag;
    logic zero_result_flag;
    logic negative;
  } fic_flags_s;

  // Handshake state, Gray along idle to done
  typedef enum logic {
    FIC_ST_IDLE = 1'b0,
    FIC_ST_DONE = 1'b1
  } fic_state_e;

endpackage : fic_pkg
`default_nettype wire

// File: hdl/fic_converter.sv
// Float to integer and integer to float conversion datapath
`include "fic_defs.svh"
`default_nettype none
module fic_converter (
  input  wire logic            clk_sys_i, // System clock, 50 MHz
  input  wire logic            rst_i,     // Async reset, active high
  input  wire logic            start_i,   // One-cycle request pulse
  input  wire fic_pkg::fic_op_e opcode_i, // Conversion opcode
  input  wire logic [15:0]     src_lo_i,  // First source word
  input  wire logic [15:0]     src_hi_i,  // Second source word
  output logic                 done_o,    // One-cycle completion pulse
  output logic [15:0]          res_lo_o,  // First result word
  output logic [15:0]          res_hi_o,  // Second result word
  output fic_pkg::fic_flags_s  flags_o    // Error, zero, negative
);
  import fic_pkg::*;

  // Opcode decode
  wire op_f2i16_w = (opcode_i == FIC_OP_F2I16);
  wire op_f2i32_w = (opcode_i == FIC_OP_F2I32);
  wire op_i16f_w  = (opcode_i == FIC_OP_I16F);
  wire op_i32f_w  = (opcode_i == FIC_OP_I32F);
  wire op_f2i_w   = op_f2i16_w | op_f2i32_w;
  wire op_i2f_w   = op_i16f_w | op_i32f_w;

  // Operand assembly, upper half in the second word
  wire [31:0] src_w = {src_hi_i, src_lo_i};

  // Float field split
  wire        f_sign_w = src_w[31];
  wire [7:0]  f_exp_w  = src_w[30:23];
  wire [22:0] f_frac_w = src_w[22:0];
  wire        exp_ones_w = (f_exp_w == `FIC_EXP_ALL1);
  wire        f_nan_w  = exp_ones_w & (f_frac_w != 23'h0);

  // Hidden one only for normalized values; denormals truncate to zero anyway
  wire [23:0] f_mant_w = {(f_exp_w != 8'h00), f_frac_w};
  wire        f_small_w = (f_exp_w < `FIC_EXP_BIAS);
  wire [8:0]  f_sh_w = {1'b0, f_exp_w} - {1'b0, `FIC_EXP_BIAS};
  // Shift of 32 or more always overflows, infinity and NaN included
  wire        f_big_w = ~f_small_w & (f_sh_w >= `FIC_SHIFT_LIM);
  wire        f_sh_right_w = (f_sh_w <= `FIC_FRAC_W);
  wire [8:0]  rsh_w = `FIC_FRAC_W - f_sh_w;
  wire [8:0]  lsh_w = f_sh_w - `FIC_FRAC_W;
  wire [31:0] mant32_w = {8'h00, f_mant_w};

  // Integer magnitude; right shift drops the fraction bits
  wire [31:0] mag_r_w = mant32_w >> rsh_w[4:0];
  wire [31:0] mag_l_w = mant32_w << lsh_w[4:0];
  wire [31:0] f_mag_w = (f_small_w | f_big_w) ? 32'h0000_0000 :
                        (f_sh_right_w ? mag_r_w : mag_l_w);

  // Sign applied to the magnitude gives truncation toward zero
  wire [31:0] f_int_w = f_sign_w ? (32'h0000_0000 - f_mag_w) : f_mag_w;

  // Range checks on the truncated value
  // Negative side reaches one step further, so -32768.9 still fits in 16 bits
  wire ovf16_w = f_sign_w ? (f_mag_w > `FIC_I16_NEG_MAG) :
                            (f_mag_w > `FIC_I16_POS_MAX);
  wire ovf32_w = f_sign_w ? (f_mag_w > `FIC_I32_NEG_MAG) :
                            (f_mag_w > `FIC_I32_POS_MAX);
  wire err16_w = f_nan_w | f_big_w | ovf16_w;
  wire err32_w = f_nan_w | f_big_w | ovf32_w;

  // Integer source, 16-bit form sign-extended
  wire [31:0] i_src_w = op_i16f_w ? {{16{src_lo_i[15]}}, src_lo_i} : src_w;
  wire        i_sign_w = i_src_w[31];
  // Magnitude of the most negative value still fits unsigned
  wire [31:0] i_mag_w = i_sign_w ? (32'h0000_0000 - i_src_w) : i_src_w;

  // Leading zero count, one stage per bit; the highest set bit has the last word
  wire [5:0]  lz_chain_w [0:32];
  assign lz_chain_w[0] = 6'h20;
  for (genvar gi = 0; gi < 32; gi++) begin : g_lead_zero
    assign lz_chain_w[gi+1] = i_mag_w[gi] ? 6'(31 - gi) : lz_chain_w[gi];
  end
  wire [5:0]  lz_w   = lz_chain_w[32];
  wire [31:0] norm_w = i_mag_w << lz_w[4:0];
  wire [7:0]  i_exp_w = `FIC_EXP_TOP - {2'b00, lz_w};

  // Round to nearest even on the bits below the 24 kept
  // Sticky keeps ties honest when set bits lie below the guard bit
  wire guard_w  = norm_w[7];
  wire sticky_w = |norm_w[6:0];
  wire lsb_w    = norm_w[8];
  wire round_w  = guard_w & (sticky_w | lsb_w);
  // Carry out of the fraction bumps the exponent, which is what we want
  wire [30:0] i_body_w = {i_exp_w, norm_w[30:8]} + {30'h0000_0000, round_w};
  wire        i_zero_w = (i_mag_w == 32'h0000_0000);
  wire [31:0] i_flt_w  = i_zero_w ? 32'h0000_0000 : {i_sign_w, i_body_w};

  // Result selection per opcode
  wire [31:0] res16_w = {16'h0000, f_int_w[15:0]};
  wire [31:0] res_next = op_f2i16_w ? res16_w :
                         op_f2i32_w ? f_int_w :
                         op_i2f_w   ? i_flt_w :
                                      `FIC_RES_RST;

  // Flags per opcode; unknown opcodes report an error
  wire err_next = op_f2i16_w ? err16_w :
                  op_f2i32_w ? err32_w :
                  op_i2f_w   ? 1'b0 :
                               1'b1;
  wire zero_next = op_f2i16_w ? (f_int_w[15:0] == 16'h0000) :
                   op_f2i32_w ? (f_int_w == 32'h0000_0000) :
                   op_i2f_w   ? (i_flt_w[30:0] == 31'h0000_0000) :
                                1'b0;
  wire neg_next = op_f2i16_w ? f_int_w[15] :
                  op_f2i32_w ? f_int_w[31] :
                  op_i2f_w   ? i_flt_w[31] :
                               1'b0;
  wire fic_flags_s flags_next = '{error_flag:       err_next,
                                  zero_result_flag: zero_next,
                                  negative:         neg_next};

  // Handshake state; a start in the done cycle is taken as well
  // No busy state: the datapath is one cycle deep, so no request is refused
  fic_state_e state_reg;
  wire fic_state_e state_next = start_i ? FIC_ST_DONE : FIC_ST_IDLE;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= FIC_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Result and flags held until the next request
  // Holding them lets the sequencer read late without a second handshake
  logic [31:0] res_reg;
  fic_flags_s  flags_reg;
  fic_op_e     op_reg;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      res_reg   <= `FIC_RES_RST;
      flags_reg <= '0;
      op_reg    <= FIC_OP_F2I16;
    end else if (start_i) begin
      res_reg   <= res_next;
      flags_reg <= flags_next;
      op_reg    <= opcode_i;
    end
  end

  // Outputs, second word holds the upper half
  assign done_o   = (state_reg == FIC_ST_DONE);
  assign res_lo_o = res_reg[15:0];
  assign res_hi_o = res_reg[31:16];
  assign flags_o  = flags_reg;

  // Checks on the datapath outputs
  wire [31:0] res_w = {res_hi_o, res_lo_o};
  wire last_f2i_w = (op_reg == FIC_OP_F2I16) | (op_reg == FIC_OP_F2I32);
  wire last_i2f_w = (op_reg == FIC_OP_I16F) | (op_reg == FIC_OP_I32F);

  a_done_pulse: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    start_i |=> done_o ##1 (done_o == $past(start_i)))
    else $error("done did not follow start");

  a_trunc_pos: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_f2i16_w && src_w == 32'h4060_0000) |=>
      (res_lo_o == 16'h0003 && !flags_o.error_flag))
    else $error("positive truncation wrong");

  a_trunc_neg: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_f2i16_w && src_w == 32'hC060_0000) |=>
      (res_lo_o == 16'hFFFD && flags_o.negative))
    else $error("negative truncation wrong");

  a_range_16: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_f2i16_w && src_w == 32'h4700_0000) |=> flags_o.error_flag)
    else $error("16-bit overflow not flagged");

  a_range_32: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_f2i32_w && src_w == 32'hCF00_0000) |=>
      (res_w == 32'h8000_0000 && !flags_o.error_flag))
    else $error("32-bit minimum mishandled");

  a_nan_error: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_f2i_w && f_nan_w) |=> flags_o.error_flag)
    else $error("NaN source not flagged");

  a_f2i_flags: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (done_o && last_f2i_w) |->
      (flags_o.zero_result_flag == ((op_reg == FIC_OP_F2I16) ?
         (res_lo_o == 16'h0000) : (res_w == 32'h0000_0000))))
    else $error("zero flag wrong after float to integer");

  a_f2i_neg: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (done_o && last_f2i_w) |->
      (flags_o.negative == ((op_reg == FIC_OP_F2I16) ? res_lo_o[15] : res_hi_o[15])))
    else $error("negative flag wrong after float to integer");

  a_i2f_noerr: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (done_o && last_i2f_w) |->
      (!flags_o.error_flag &&
       flags_o.zero_result_flag == (res_w[30:0] == 31'h0000_0000) &&
       flags_o.negative == res_hi_o[15]))
    else $error("flags wrong after integer to float");

  a_exact_24: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_i32f_w && src_w == 32'h00FF_FFFF) |=> (res_w == 32'h4B7F_FFFF))
    else $error("24-bit value not exact");

  a_tie_even: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_i32f_w && src_w == 32'h0100_0003) |=> (res_w == 32'h4B80_0002))
    else $error("tie not rounded to even");

  a_i16_word: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_i16f_w && src_lo_i == 16'hFFFD) |=> (res_w == 32'hC040_0000))
    else $error("16-bit integer to float wrong");

  // Range edges, worked examples and the holding of results
  a_unity_bias: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_f2i16_w && src_w == 32'h3F80_0000) |=>
      (res_w == 32'h0000_0001 && !flags_o.error_flag && !flags_o.zero_result_flag))
    else $error("exponent bias wrong");

  a_trunc_32: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_f2i32_w && src_w == 32'hC060_0000) |=>
      (res_w == 32'hFFFF_FFFD && flags_o.negative && !flags_o.error_flag))
    else $error("32-bit truncation wrong");

  a_hi_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_f2i16_w) |=> (res_hi_o == 16'h0000))
    else $error("upper word not clear after 16-bit result");

  a_i16_min: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_f2i16_w && src_w == 32'hC700_0080) |=>
      (res_lo_o == 16'h8000 && !flags_o.error_flag))
    else $error("16-bit minimum mishandled");

  a_i16_max: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_f2i16_w && src_w == 32'h46FF_FF00) |=>
      (res_lo_o == 16'h7FFF && !flags_o.error_flag))
    else $error("16-bit maximum mishandled");

  a_i16_below: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_f2i16_w && src_w == 32'hC700_0100) |=>
      (res_lo_o == 16'h7FFF && flags_o.error_flag))
    else $error("16-bit underflow not flagged");

  a_inf_error: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_f2i32_w && src_w == 32'h7F80_0000) |=>
      (res_w == 32'h0000_0000 && flags_o.error_flag))
    else $error("infinity not flagged");

  a_i32_above: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_f2i32_w && src_w == 32'h4F00_0000) |=> flags_o.error_flag)
    else $error("32-bit overflow not flagged");

  a_tiny_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_f2i_w && f_small_w) |=>
      (res_w == 32'h0000_0000 && !flags_o.error_flag && flags_o.zero_result_flag))
    else $error("small value not cleared to zero");

  a_i32_pos: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_f2i32_w && src_w == 32'h4EFF_FFFF) |=>
      (res_w == 32'h7FFF_FF80 && !flags_o.error_flag))
    else $error("large 32-bit conversion wrong");

  a_i2f_zero: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_i32f_w && src_w == 32'h0000_0000) |=>
      (res_w == 32'h0000_0000 && flags_o.zero_result_flag))
    else $error("zero integer not converted to zero");

  a_i16_one: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_i16f_w && src_lo_i == 16'h0001) |=> (res_w == 32'h3F80_0000))
    else $error("16-bit one not converted");

  a_i16_pos: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_i16f_w && src_lo_i == 16'h0003) |=>
      (res_w == 32'h4040_0000 && !flags_o.negative))
    else $error("positive 16-bit integer to float wrong");

  a_i32_min: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_i32f_w && src_w == 32'h8000_0000) |=>
      (res_w == 32'hCF00_0000 && flags_o.negative))
    else $error("32-bit minimum not converted");

  a_neg_exact: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_i32f_w && src_w == 32'hFF00_0001) |=> (res_w == 32'hCB7F_FFFF))
    else $error("negative 24-bit value not exact");

  a_i2f_sign: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (start_i && op_i32f_w && src_w[31]) |=> flags_o.negative)
    else $error("negative integer gave no negative flag");

  a_res_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !start_i |=> ($stable(res_w) && $stable(flags_o)))
    else $error("result moved without a request");

  // Main scenarios
  c_f2i_err: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    done_o && last_f2i_w && flags_o.error_flag);
  c_i2f_neg: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    done_o && last_i2f_w && flags_o.negative);
  c_back2back: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    start_i ##1 start_i ##1 done_o);
  c_unknown_op: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    done_o && !last_f2i_w && !last_i2f_w);
  c_f2i_zero: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    done_o && last_f2i_w && flags_o.zero_result_flag);

endmodule : fic_converter
`default_nettype wire

// File: verification/fic_seq_model.sv
// Sequencer model that feeds the converter and captures its answers
`default_nettype none
module fic_seq_model (
  input  wire logic                clk_sys_i, // System clock
  input  wire logic                rst_i,     // Async reset, active high
  output logic                     start_o,   // One-cycle request
  output fic_pkg::fic_op_e         opcode_o,  // Conversion opcode
  output logic [15:0]              src_lo_o,  // First source word
  output logic [15:0]              src_hi_o,  // Second source word
  input  wire logic                done_i,    // Completion pulse
  input  wire logic [15:0]         res_lo_i,  // First result word
  input  wire logic [15:0]         res_hi_i,  // Second result word
  input  wire fic_pkg::fic_flags_s flags_i    // Returned flags
);
  timeunit 1ns;
  timeprecision 1ps;
  import fic_pkg::*;
  logic [42:0] req_q[$];  // Gap, opcode, hi, lo
  logic [36:0] res_q[$];  // Done, sent, flags, hi, lo
  logic        sent_reg;  // Start went out at the last edge
  logic [34:0] last_out;
  logic [42:0] cur;
  int          hold_bad;
  initial begin
    {start_o, src_lo_o, src_hi_o, sent_reg, last_out, hold_bad} = '0;
    opcode_o = FIC_OP_F2I16;
  end
  // Answers taken one edge after the start; idle lines toggle so stale data never looks valid
  always @(posedge clk_sys_i) begin
    if (sent_reg || done_i) res_q.push_back({done_i, sent_reg, flags_i, res_hi_i, res_lo_i});
    else if (!rst_i && {flags_i, res_hi_i, res_lo_i} !== last_out) hold_bad++;
    last_out = {flags_i, res_hi_i, res_lo_i};
    sent_reg <= start_o && !rst_i;
    if (!rst_i && req_q.size() > 0 && !req_q[0][42]) begin
      cur = req_q.pop_front();
      start_o <= 1'b1;
      opcode_o <= fic_op_e'(cur[41:32]);
      {src_hi_o, src_lo_o} <= cur[31:0];
    end else begin
      if (req_q.size() > 0) req_q[0][42] = 1'b0;
      start_o <= 1'b0;
      src_lo_o <= ~src_lo_o;
      src_hi_o <= ~src_hi_o;
    end
  end
endmodule : fic_seq_model
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the conversion datapath
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fic_pkg::*;
  logic        clk_sys_i, rst_i, start_i, done_o;
  fic_op_e     opcode_i;
  logic [15:0] src_lo_i, src_hi_i, res_lo_o, res_hi_o;
  fic_flags_s  flags_o;
  int          n_errors, n_compared;
  logic [31:0] lfsr;
  logic [35:0] exp_q[$];  // Compare-all, flags, result
  logic [31:0] fv[14] = '{32'h4060_0000, 32'hC060_0000, 32'h46FF_FF00, 32'h4700_0000,
    32'hC700_0080, 32'hC700_0100, 32'h7FC0_0000, 32'h7F80_0000, 32'h8000_0001,
    32'h8000_0000, 32'h4F00_0000, 32'hCF00_0000, 32'h4EFF_FFFF, 32'h3F80_0000};
  logic [31:0] iv[13] = '{32'h0000_0000, 32'h0000_0001, 32'hFFFF_FFFF, 32'h0000_7FFF,
    32'hFFFF_8000, 32'h00FF_FFFF, 32'hFF00_0001, 32'h0100_0001, 32'h0100_0003,
    32'h7FFF_FFFF, 32'h8000_0000, 32'hFFFF_FFFD, 32'h0000_0003};
  fic_converter dut_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_i(start_i),
    .opcode_i(opcode_i), .src_lo_i(src_lo_i), .src_hi_i(src_hi_i), .done_o(done_o),
    .res_lo_o(res_lo_o), .res_hi_o(res_hi_o), .flags_o(flags_o));
  fic_seq_model seq_u (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .start_o(start_i),
    .opcode_o(opcode_i), .src_lo_o(src_lo_i), .src_hi_o(src_hi_i), .done_i(done_o),
    .res_lo_i(res_lo_o), .res_hi_i(res_hi_o), .flags_i(flags_o));
  // Clock at 50 MHz
  initial begin
    clk_sys_i = 1'b0;
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next
  // Truncating reference; out-of-range values wrap, shifts of 32 or more give 0
  function automatic logic [35:0] ref_f2i(input logic [31:0] b, input logic wide);
    longint m, v;
    logic err, big;
    logic [31:0] r;
    big = (b[30:23] >= 8'h9F); // Infinity and NaN land here as well
    m = (b[30:23] == 8'h00) ? 0 : {1'b1, b[22:0]};
    if (b[30:23] < 8'h7F || big) v = 0;
    else if (b[30:23] >= 8'h96) v = m << (b[30:23] - 150);
    else v = m >> (150 - b[30:23]);
    if (b[31]) v = -v;
    err = big || (wide ? (v > 64'sh7FFF_FFFF || v < -64'sh8000_0000)
      : (v > 32767 || v < -32768));
    r = wide ? v[31:0] : {16'h0000, v[15:0]};
    return {1'b1, err, wide ? r == 0 : r[15:0] == 0, wide ? r[31] : r[15], r};
  endfunction : ref_f2i
  // Integer to float with round to nearest, ties to even
  function automatic logic [35:0] ref_i2f(input longint v);
    longint mag, mt, rem, half;
    int p, sh;
    logic [31:0] r;
    mag = (v < 0) ? -v : v;
    p = 0;
    for (int i = 0; i < 33; i++) if (mag[i]) p = i;
    sh = (p > 23) ? p - 23 : 0;
    rem = mag & ((64'd1 << sh) - 1);
    half = (sh > 0) ? (64'd1 << (sh - 1)) : 64'd0;
    mt = (p > 23) ? mag >> sh : mag << (23 - p);
    if (sh > 0 && (rem > half || (rem == half && mt[0]))) mt++;
    if (mt[24]) begin
      mt = mt >> 1;
      p++;
    end
    r = (mag == 0) ? 32'h0000_0000 : {v < 0, 8'(p + 127), mt[22:0]};
    return {2'b10, r[30:0] == 0, r[31], r};
  endfunction : ref_i2f
  task automatic issue(input logic gap, input logic [9:0] op, input logic [31:0] s);
    logic [35:0] e;
    case (op)
      FIC_OP_F2I16: e = ref_f2i(s, 1'b0);
      FIC_OP_F2I32: e = ref_f2i(s, 1'b1);
      FIC_OP_I16F:  e = ref_i2f(longint'($signed(s[15:0])));
      FIC_OP_I32F:  e = ref_i2f(longint'($signed(s)));
      default:      e = {2'b11, 34'h0};
    endcase
    seq_u.req_q.push_back({gap, op, s});
    exp_q.push_back(e);
  endtask : issue
  task automatic cmp(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : cmp
  task automatic check_all();
    logic [35:0] e;
    logic [36:0] g;
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      g = (seq_u.res_q.size() > 0) ? seq_u.res_q.pop_front() : '0;
      cmp(g[36:35] === 2'b11, "done not one cycle after start");
      cmp(g[34] === e[34], "error flag");
      if (e[35]) cmp(g[33:0] === e[33:0], "result or flags");
    end
    cmp(seq_u.res_q.size() == 0, "done without a matching start");
  endtask : check_all
  task automatic wrap_up();
    $display("errors %0d, comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    n_errors++;
    wrap_up();
  end
  // Directed edges, back-to-back and spaced, then biased random traffic
  initial begin
    n_errors = 0;
    n_compared = 0;
    lfsr = 32'h36f4;
    rst_i = 1'b1;
    repeat (8) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    #1 cmp({done_o, res_hi_o, res_lo_o, flags_o} === 36'h0, "reset values");
    foreach (fv[i]) for (int k = 0; k < 2; k++) issue(i[0], 10'h1C2 + k, fv[i]);
    foreach (iv[i]) for (int k = 0; k < 2; k++)
      issue(i[0], 10'h1C4 + k, iv[i] ^ (k ? 32'h0 : {lfsr[15:0], 16'h0000}));
    for (int n = 0; n < 200; n++) begin
      lfsr = lfsr_next(lfsr);
      issue(lfsr[7], 10'h1C2 + n % 4, (n % 4 < 2) ?
        {lfsr[31], 8'd120 + 8'(lfsr[30:23] % 46), lfsr[22:0]} : lfsr);
    end
    issue(1'b0, 10'h000, lfsr);
    for (int w = 0; w < 2000 && seq_u.req_q.size() > 0; w++) @(posedge clk_sys_i);
    repeat (3) @(posedge clk_sys_i);
    check_all();
    cmp(seq_u.hold_bad == 0, "outputs moved without a start");
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
